// ===== logic/csb_unit.sv
// Conditional skip and relative branch execution unit with its program counter.
// Assumes decode offers one instruction at a time, held while ready is low.
`timescale 1ns/1ns
`include "csb_consts.svh"

module csb_unit
    import csb_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Program counter load from fetch
    input wire logic pc_load,
    input wire logic [`CSB_PC_W-1:0] pc_load_value,
    // Decoded instruction
    input wire logic instr_valid,
    input wire csb_op_e op,
    input wire logic [`CSB_BIT_W-1:0] bit_sel,
    input wire logic [`CSB_OFS_W-1:0] offset,
    input wire logic next_two_word,
    // Operands
    input wire logic [`CSB_DATA_W-1:0] reg_rdata,
    input wire logic [`CSB_DATA_W-1:0] io_rdata,
    input wire logic [`CSB_DATA_W-1:0] status_flags_register,
    // Handshake
    output logic ready,
    // Results
    output logic [`CSB_PC_W-1:0] pc,
    output logic done,
    output logic taken,
    output logic [`CSB_CYC_W-1:0] cycles
);

    // ==========================================================
    // Condition evaluation
    logic cond_true;
    logic is_skip;
    logic is_branch;

    csb_cond u_cond (
        .op(op),
        .bit_sel(bit_sel),
        .reg_rdata(reg_rdata),
        .io_rdata(io_rdata),
        .status_flags_register(status_flags_register),
        .cond_true(cond_true),
        .is_skip(is_skip),
        .is_branch(is_branch)
    );

    // ==========================================================
    // State
    csb_state_e state_q;
    csb_state_e state_d;
    csb_pc_t pc_q;
    csb_pc_t pc_d;
    logic [`CSB_CYC_W-1:0] stall_q;
    logic [`CSB_CYC_W-1:0] stall_d;
    logic done_q;
    logic done_d;
    logic taken_q;
    logic taken_d;
    logic [`CSB_CYC_W-1:0] cycles_q;
    logic [`CSB_CYC_W-1:0] cycles_d;

    // ==========================================================
    // Target arithmetic
    csb_pc_t ofs_ext;
    csb_pc_t seq_pc;
    csb_pc_t branch_pc;
    csb_pc_t skip_pc;
    csb_pc_t exec_pc;
    logic [`CSB_CYC_W-1:0] exec_cycles;
    logic accept;

    // Sign extension lets branches reach backward as well as forward
    assign ofs_ext = {{(`CSB_PC_W-`CSB_OFS_W){offset[`CSB_OFS_W-1]}}, offset};
    assign seq_pc = pc_q + `CSB_STEP_SEQ;
    assign branch_pc = pc_q + ofs_ext + `CSB_STEP_SEQ;
    // A two-word follower needs one more word to clear it
    assign skip_pc = pc_q + (next_two_word ? `CSB_STEP_SKIP_TWO : `CSB_STEP_SKIP_ONE);

    assign ready = (state_q == ST_IDLE);
    assign accept = instr_valid && ready;

    // ==========================================================
    // Hit decode
    logic skip_hit;
    logic branch_hit;
    logic load_ok;

    assign skip_hit = is_skip && cond_true;
    assign branch_hit = is_branch && cond_true;
    // An offered instruction wins over a load in the same cycle
    assign load_ok = pc_load && ready && !instr_valid;

    // ==========================================================
    // Resulting PC for one instruction
    always_comb begin
        exec_pc = seq_pc;
        if (skip_hit) begin
            exec_pc = skip_pc;
        end else if (branch_hit) begin
            exec_pc = branch_pc;
        end
    end

    // ==========================================================
    // Cycle count for one instruction
    always_comb begin
        exec_cycles = `CSB_CYC_ONE;
        if (skip_hit) begin
            // A two-word follower costs one more fetch cycle
            exec_cycles = next_two_word ? `CSB_CYC_THREE : `CSB_CYC_TWO;
        end else if (branch_hit) begin
            exec_cycles = `CSB_CYC_TWO;
        end
    end

    // ==========================================================
    // Control group: state, stall counter and end pulse
    always_comb begin
        state_d = state_q;
        stall_d = stall_q;
        done_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    if (exec_cycles == `CSB_CYC_ONE) begin
                        // Single-cycle work ends at the very next edge
                        done_d = 1'b1;
                    end else begin
                        stall_d = exec_cycles - `CSB_CNT_DEC;
                        state_d = ST_STALL;
                    end
                end
            end
            ST_STALL: begin
                if (stall_q == `CSB_CNT_ONE) begin
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
                stall_d = stall_q - `CSB_CNT_DEC;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            stall_q <= `CSB_CYC_RST;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            stall_q <= stall_d;
            done_q <= done_d;
        end
    end

    // ==========================================================
    // Program counter group
    always_comb begin
        pc_d = pc_q;
        if (accept) begin
            // PC moves at once; the stall only pads the cycle count
            pc_d = exec_pc;
        end else if (load_ok) begin
            // Loads are refused mid-instruction to keep the count honest
            pc_d = pc_load_value;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= `CSB_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ==========================================================
    // Result group: outcome and cycle count of the last instruction
    always_comb begin
        taken_d = taken_q;
        cycles_d = cycles_q;
        if (accept) begin
            taken_d = cond_true;
            cycles_d = exec_cycles;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            taken_q <= 1'b0;
            cycles_q <= `CSB_CYC_RST;
        end else begin
            taken_q <= taken_d;
            cycles_q <= cycles_d;
        end
    end

    // ==========================================================
    // Outputs
    assign pc = pc_q;
    assign done = done_q;
    assign taken = taken_q;
    assign cycles = cycles_q;

endmodule

// ===== logic/csb_consts.svh
// Constants for the conditional skip and branch unit.
// Assumes inclusion by bare name from package and modules.
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH

// ==========================================================
// Widths
`define CSB_PC_W 16
`define CSB_OFS_W 7
`define CSB_DATA_W 8
`define CSB_BIT_W 3
`define CSB_OP_W 4
`define CSB_CYC_W 2

// ==========================================================
// Reset values
`define CSB_PC_RST 16'h0000
`define CSB_CYC_RST 2'h0

// ==========================================================
// Status flag positions
`define CSB_FLAG_C 3'h0
`define CSB_FLAG_Z 3'h1
`define CSB_FLAG_N 3'h2
`define CSB_FLAG_V 3'h3
`define CSB_FLAG_H 3'h5

// ==========================================================
// Program counter steps
`define CSB_STEP_SEQ 16'h0001
`define CSB_STEP_SKIP_ONE 16'h0002
`define CSB_STEP_SKIP_TWO 16'h0003

// ==========================================================
// Cycle counts
`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3
`define CSB_CNT_ONE 2'h1
`define CSB_CNT_DEC 2'h1

`endif

// ===== logic/csb_pkg.sv
// Types for the conditional skip and branch unit.
// Assumes csb_consts.svh is on the include path.
`include "csb_consts.svh"

package csb_pkg;

    // ==========================================================
    // Operation select from decode
    typedef enum logic [`CSB_OP_W-1:0] {
        OP_SEQUENTIAL = 4'h0,
        OP_SKIP_IF_REG_BIT_SET = 4'h1,
        OP_SKIP_IF_IO_BIT_CLEAR = 4'h2,
        OP_SKIP_IF_IO_BIT_SET = 4'h3,
        OP_BRANCH_IF_FLAG_SET = 4'h4,
        OP_BRANCH_IF_FLAG_CLEAR = 4'h5,
        OP_BRANCH_IF_EQUAL = 4'h6,
        OP_BRANCH_IF_NOT_EQUAL = 4'h7,
        OP_BRANCH_IF_CARRY_CLEAR = 4'h8,
        OP_BRANCH_IF_SAME_OR_HIGHER = 4'h9,
        OP_BRANCH_IF_MINUS = 4'hA,
        OP_BRANCH_IF_SIGNED_GE = 4'hB,
        OP_BRANCH_IF_HALF_CARRY_SET = 4'hC,
        OP_BRANCH_IF_HALF_CARRY_CLEAR = 4'hD
    } csb_op_e;

    // ==========================================================
    // Execution state
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_STALL
    } csb_state_e;

    typedef logic [`CSB_PC_W-1:0] csb_pc_t;

endpackage

// ===== logic/csb_cond.sv
// Condition evaluator for skips and relative branches.
// Assumes operands are stable in the cycle the instruction is offered.
`timescale 1ns/1ns
`include "csb_consts.svh"

module csb_cond
    import csb_pkg::*;
(
    // Decoded instruction
    input wire csb_op_e op,
    input wire logic [`CSB_BIT_W-1:0] bit_sel,
    // Operands
    input wire logic [`CSB_DATA_W-1:0] reg_rdata,
    input wire logic [`CSB_DATA_W-1:0] io_rdata,
    input wire logic [`CSB_DATA_W-1:0] status_flags_register,
    // Result
    output logic cond_true,
    output logic is_skip,
    output logic is_branch
);

    // ==========================================================
    // Flag taps
    logic flag_c;
    logic flag_z;
    logic flag_n;
    logic flag_v;
    logic flag_h;
    logic flag_sel;

    assign flag_c = status_flags_register[`CSB_FLAG_C];
    assign flag_z = status_flags_register[`CSB_FLAG_Z];
    assign flag_n = status_flags_register[`CSB_FLAG_N];
    assign flag_v = status_flags_register[`CSB_FLAG_V];
    assign flag_h = status_flags_register[`CSB_FLAG_H];
    assign flag_sel = status_flags_register[bit_sel];

    // ==========================================================
    // Condition select
    always_comb begin
        cond_true = 1'b0;
        is_skip = 1'b0;
        is_branch = 1'b1;
        unique case (op)
            OP_SKIP_IF_REG_BIT_SET: begin
                cond_true = reg_rdata[bit_sel];
                is_skip = 1'b1;
                is_branch = 1'b0;
            end
            OP_SKIP_IF_IO_BIT_CLEAR: begin
                cond_true = ~io_rdata[bit_sel];
                is_skip = 1'b1;
                is_branch = 1'b0;
            end
            OP_SKIP_IF_IO_BIT_SET: begin
                cond_true = io_rdata[bit_sel];
                is_skip = 1'b1;
                is_branch = 1'b0;
            end
            OP_BRANCH_IF_FLAG_SET: cond_true = flag_sel;
            OP_BRANCH_IF_FLAG_CLEAR: cond_true = ~flag_sel;
            OP_BRANCH_IF_EQUAL: cond_true = flag_z;
            OP_BRANCH_IF_NOT_EQUAL: cond_true = ~flag_z;
            OP_BRANCH_IF_CARRY_CLEAR: cond_true = ~flag_c;
            OP_BRANCH_IF_SAME_OR_HIGHER: cond_true = ~flag_c;
            OP_BRANCH_IF_MINUS: cond_true = flag_n;
            OP_BRANCH_IF_SIGNED_GE: cond_true = ~(flag_n ^ flag_v);
            OP_BRANCH_IF_HALF_CARRY_SET: cond_true = flag_h;
            OP_BRANCH_IF_HALF_CARRY_CLEAR: cond_true = ~flag_h;
            // Sequential and unused codes simply fall through to PC+1
            default: begin
                cond_true = 1'b0;
                is_branch = 1'b0;
            end
        endcase
    end

endmodule

// ===== test/csb_unit_props.sv
// Port checker for the skip and branch unit.
// Assumes a bind onto csb_unit and one clock domain.
`timescale 1ns/1ns
module csb_unit_props import csb_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Instruction
    input wire logic instr_valid,
    input wire csb_op_e op,
    input wire logic [2:0] bit_sel,
    input wire logic [6:0] offset,
    input wire logic next_two_word,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] status_flags_register,
    // Results
    input wire logic ready,
    input wire logic [15:0] pc,
    input wire logic done,
    input wire logic taken,
    input wire logic [1:0] cycles
);
    // ==========================================
    // Helpers
    logic acc, br, skp, iob, rgb, fb, zf, nv;
    logic [15:0] kx;
    assign acc = instr_valid && ready;
    assign br = op >= OP_BRANCH_IF_FLAG_SET && op <= OP_BRANCH_IF_HALF_CARRY_CLEAR;
    assign skp = op >= OP_SKIP_IF_REG_BIT_SET && op <= OP_SKIP_IF_IO_BIT_SET;
    assign iob = io_rdata[bit_sel];
    assign rgb = reg_rdata[bit_sel];
    assign fb = status_flags_register[bit_sel];
    assign zf = status_flags_register[1];
    assign nv = status_flags_register[2] ^ status_flags_register[3];
    assign kx = {{9{offset[6]}}, offset};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Properties
    AST_BR_PC: assert property (acc && br |=> pc == $past(pc) + (taken ? $past(kx) + 16'h1 : 16'h1))
        else $error("branch target wrong");
    AST_BR_CYC: assert property (acc && br |=> cycles == (taken ? 2'h2 : 2'h1)) else $error("branch count");
    AST_BR_STALL: assert property (acc && br ##1 taken |-> !ready && !done ##1 ready && done)
        else $error("taken branch stall wrong");
    AST_FLAG_SET: assert property (acc && op == OP_BRANCH_IF_FLAG_SET |=> taken == $past(fb))
        else $error("flag set cond");
    AST_EQ_Z: assert property (acc && op == OP_BRANCH_IF_EQUAL |=> taken == $past(zf)) else $error("eq cond");
    AST_GE_NV: assert property (acc && op == OP_BRANCH_IF_SIGNED_GE |=> taken == !$past(nv))
        else $error("signed ge cond");
    AST_IO_CLR: assert property (acc && op == OP_SKIP_IF_IO_BIT_CLEAR |=> taken == !$past(iob))
        else $error("io clear cond");
    AST_REG_SET: assert property (acc && op == OP_SKIP_IF_REG_BIT_SET |=> taken == $past(rgb))
        else $error("reg set cond");
    AST_SKIP_PC: assert property (acc && skp |=> pc - $past(pc) == {14'h0, cycles}
        && cycles == (!taken ? 2'h1 : $past(next_two_word) ? 2'h3 : 2'h2)) else $error("skip step wrong");
endmodule

bind csb_unit csb_unit_props chk_u (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .op(op),
    .bit_sel(bit_sel), .offset(offset), .next_two_word(next_two_word), .reg_rdata(reg_rdata),
    .io_rdata(io_rdata), .status_flags_register(status_flags_register), .ready(ready), .pc(pc),
    .done(done), .taken(taken), .cycles(cycles));

// ===== test/csb_decode_model.sv
// Decode-side model offering one instruction at a time.
// Assumes go is pulsed for one cycle only while idle.
`timescale 1ns/1ns
module csb_decode_model import csb_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Request from bench
    input wire logic go,
    input wire csb_op_e g_op,
    input wire logic [2:0] g_bit,
    input wire logic [6:0] g_ofs,
    input wire logic g_two,
    input wire logic ready,
    // Towards the unit
    output logic instr_valid,
    output csb_op_e op,
    output logic [2:0] bit_sel,
    output logic [6:0] offset,
    output logic next_two_word
);
    // ==========================================
    // Offer held until taken; fields inverted after, so stale values never pass
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instr_valid <= 1'h0;
            op <= OP_SEQUENTIAL;
            bit_sel <= 3'h0;
            offset <= 7'h00;
            next_two_word <= 1'h0;
        end else if (go) begin
            instr_valid <= 1'h1;
            op <= g_op;
            bit_sel <= g_bit;
            offset <= g_ofs;
            next_two_word <= g_two;
        end else if (instr_valid && ready) begin
            instr_valid <= 1'h0;
            op <= csb_op_e'(~op);
            bit_sel <= ~bit_sel;
            offset <= ~offset;
            next_two_word <= ~next_two_word;
        end
    end
endmodule

// ===== test/tb_csb_unit.sv
// Self-checking bench for the skip and branch unit.
// Assumes the decode model and bound checker are compiled before it.
`timescale 1ns/1ns
module tb_csb_unit import csb_pkg::*; ;
    // ==========================================
    // Signals
    logic mclk = 1'h0, rst_n = 1'h0, pc_load = 1'h0, go = 1'h0, g_two = 1'h0;
    logic instr_valid, next_two_word, ready, done, taken;
    csb_op_e g_op = OP_SEQUENTIAL, op;
    logic [2:0] g_bit = 3'h0, bit_sel;
    logic [6:0] g_ofs = 7'h00, offset;
    logic [7:0] reg_rdata = 8'h00, io_rdata = 8'h00, status_flags_register = 8'h00;
    logic [15:0] pc_load_value = 16'h0000, pc, epc;
    logic [1:0] cycles;
    int n_mismatch = 0, n_checks = 0;

    always #50 mclk = ~mclk;

    csb_decode_model dec_u (.mclk(mclk), .rst_n(rst_n), .go(go), .g_op(g_op), .g_bit(g_bit), .g_ofs(g_ofs),
        .g_two(g_two), .ready(ready), .instr_valid(instr_valid), .op(op), .bit_sel(bit_sel), .offset(offset),
        .next_two_word(next_two_word));
    csb_unit dut_u (.mclk(mclk), .rst_n(rst_n), .pc_load(pc_load), .pc_load_value(pc_load_value),
        .instr_valid(instr_valid), .op(op), .bit_sel(bit_sel), .offset(offset), .next_two_word(next_two_word),
        .reg_rdata(reg_rdata), .io_rdata(io_rdata), .status_flags_register(status_flags_register),
        .ready(ready), .pc(pc), .done(done), .taken(taken), .cycles(cycles));

    // ==========================================
    // Shared tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    function logic cond(csb_op_e o, logic [2:0] b, logic [7:0] r, logic [7:0] io, logic [7:0] s);
        case (o)
            OP_SKIP_IF_REG_BIT_SET: return r[b];
            OP_SKIP_IF_IO_BIT_CLEAR: return !io[b];
            OP_SKIP_IF_IO_BIT_SET: return io[b];
            OP_BRANCH_IF_FLAG_SET: return s[b];
            OP_BRANCH_IF_FLAG_CLEAR: return !s[b];
            OP_BRANCH_IF_EQUAL: return s[1];
            OP_BRANCH_IF_NOT_EQUAL: return !s[1];
            OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: return !s[0];
            OP_BRANCH_IF_MINUS: return s[2];
            OP_BRANCH_IF_SIGNED_GE: return !(s[2] ^ s[3]);
            OP_BRANCH_IF_HALF_CARRY_SET: return s[5];
            OP_BRANCH_IF_HALF_CARRY_CLEAR: return !s[5];
            default: return 1'h0;
        endcase
    endfunction

    task ld(input logic [15:0] v);
        pc_load = 1'h1;
        pc_load_value = v;
        @(posedge mclk);
        #5;
        pc_load = 1'h0;
        epc = v;
    endtask

    // One instruction through the model; expected pc tracked here, never read back
    task run(input csb_op_e o, input logic [2:0] b, input logic [6:0] k, input logic two,
        input logic [7:0] r, input logic [7:0] io, input logic [7:0] s);
        logic c, sk;
        logic [1:0] ec;
        int j;
        c = cond(o, b, r, io, s);
        sk = o inside {OP_SKIP_IF_REG_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR, OP_SKIP_IF_IO_BIT_SET};
        ec = !c ? 2'h1 : (sk && two) ? 2'h3 : 2'h2;
        epc = !c ? epc + 16'h1 : sk ? epc + {14'h0, ec} : epc + {{9{k[6]}}, k} + 16'h1;
        g_op = o;
        g_bit = b;
        g_ofs = k;
        g_two = two;
        reg_rdata = r;
        io_rdata = io;
        status_flags_register = s;
        go = 1'h1;
        j = 0;
        do begin
            @(posedge mclk);
            #5;
            go = 1'h0;
            j++;
        end while (done !== 1'h1 && j < 9);
        if (done !== 1'h1) begin
            n_mismatch++;
            complete_run();
        end
        chk(pc, epc);
        chk({13'h0, taken, cycles}, {13'h0, c, ec});
        chk({ready, 15'(j)}, {1'h1, {13'h0, ec} + 15'h1});
    endtask

    // ==========================================
    // Scenarios
    task t_skips();
        logic [7:0] v;
        ld(16'h0010);
        for (int i = 0; i < 12; i++) begin
            v = i[3] ? 8'h55 : 8'hAA;
            run(csb_op_e'(1 + i % 3), i[2:0], 7'h00, i[1], v, v, 8'h00);
        end
    endtask

    task t_flags();
        logic [7:0] sv [3];
        logic [6:0] k;
        sv = '{8'h00, 8'hFF, 8'h24};
        ld(16'h0100);
        for (int i = 0; i < 15; i++) begin
            k = i[0] ? 7'h7E : 7'h05;
            run(csb_op_e'(4 + i % 5), i[2:0], k, 1'h0, 8'h00, 8'h00, sv[i / 5]);
            run(csb_op_e'(9 + i % 5), i[2:0], k, 1'h0, 8'h00, 8'h00, sv[i / 5]);
        end
    endtask

    // Offset extremes wrap the counter both ways
    task t_edges();
        ld(16'h0000);
        run(OP_BRANCH_IF_EQUAL, 3'h0, 7'h40, 1'h0, 8'h00, 8'h00, 8'h02);
        run(OP_BRANCH_IF_NOT_EQUAL, 3'h0, 7'h3F, 1'h0, 8'h00, 8'h00, 8'h00);
        run(OP_SEQUENTIAL, 3'h7, 7'h3F, 1'h1, 8'hFF, 8'hFF, 8'hFF);
        run(csb_op_e'(4'hE), 3'h7, 7'h3F, 1'h1, 8'hFF, 8'hFF, 8'hFF);
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        #5;
        rst_n = 1'h1;
        t_skips();
        t_flags();
        t_edges();
        complete_run();
    end
endmodule
